/* File: core/irq_vector_pkg.sv */
// Purpose: shared constants and types for interrupt vector placement
// Assumes: 12-bit word program addresses, 16 interrupt sources plus reset
// Notes: slot offsets are relative to the vector table base
package irq_vector_pkg;
    localparam int ADDR_W = 12;                     // Program word address width
    localparam int NUM_SRC = 16;                    // Interrupt sources, reset excluded
    localparam logic [11:0] RESET_APP_ADDR = 12'h000;   // Reset entry, application area
    localparam logic [11:0] SLOT_EXT_IRQ_0 = 12'h001;
    localparam logic [11:0] SLOT_EXT_IRQ_1 = 12'h002;
    localparam logic [11:0] SLOT_T1_CAPTURE = 12'h003;
    localparam logic [11:0] SLOT_T1_COMPARE_A = 12'h004;
    localparam logic [11:0] SLOT_T1_COMPARE_B = 12'h005;
    localparam logic [11:0] SLOT_T1_OVERFLOW = 12'h006;
    localparam logic [11:0] SLOT_T0_OVERFLOW = 12'h007;
    localparam logic [11:0] SLOT_SERIAL_DONE = 12'h008;
    localparam logic [11:0] SLOT_RX_DONE = 12'h009;
    localparam logic [11:0] SLOT_TX_EMPTY = 12'h00A;
    localparam logic [11:0] SLOT_TX_DONE = 12'h00B;
    localparam logic [11:0] SLOT_COMPARATOR = 12'h00C;
    localparam logic [11:0] SLOT_EXT_IRQ_2 = 12'h00D;
    localparam logic [11:0] SLOT_T0_COMPARE = 12'h00E;
    localparam logic [11:0] SLOT_EEPROM_READY = 12'h00F;
    localparam logic [11:0] SLOT_STORE_READY = 12'h010;
    localparam logic [11:0] BOOT_RESET_ADDR_DEF = 12'hC00;  // Default boot start, plain value
    localparam logic FUSE_UNPROGRAMMED = 1'b1;      // Fuse reads 1 when unprogrammed
    localparam int CHANGE_WINDOW_CYC = 4;           // Change enable lifetime in cycles
    localparam logic [7:0] CTRL_RESET = 8'h00;      // Control register reset value
    localparam int CTRL_SEL_BIT = 1;                // Table select bit position
    localparam int CTRL_CE_BIT = 0;                 // Change enable bit position
    localparam logic [7:0] CTRL_RW_MASK = 8'h03;    // Implemented control bits
    localparam logic [3:0] REG_CTRL = 4'h0;         // Control register address
    localparam logic [3:0] REG_STATUS = 4'h1;       // Placement status register address
    localparam logic [3:0] REG_IRQ_STATUS = 4'h2;   // Sticky event status
    localparam logic [3:0] REG_IRQ_MASK = 4'h3;     // Event mask
    localparam int EVT_BLOCK_END = 0;               // Event bit: block window ended
    localparam int EVT_SEL_CHANGED = 1;             // Event bit: table select changed
    localparam int EVT_CE_TIMEOUT = 2;              // Event bit: change enable expired

    typedef struct packed {
        logic valid;                // A vector is requested
        logic [3:0] index;          // Source index, 0 is slot 0x001
        logic [11:0] addr;          // Absolute vector address
    } vector_req_t;

    typedef struct packed {
        logic [3:0] addr;           // Register address
        logic [7:0] wdata;          // Write data
        logic wr;                   // Write strobe
        logic rd;                   // Read strobe
    } reg_req_t;
endpackage : irq_vector_pkg

/* File: core/irq_priority_pick.sv */
// Purpose: pick the lowest numbered pending source
// Assumes: bit 0 is the highest priority source
// Notes: purely combinational
`timescale 1ns/10ps
module irq_priority_pick import irq_vector_pkg::*; #(
    parameter int N = NUM_SRC
) (
    input wire logic [N-1:0] pending_i,     // Enabled pending requests
    output logic found_o,                   // Any request pending
    output logic [3:0] index_o              // Winning source index
);
    // ---------------------------------------------------------------
    // Scan from the top so the lowest index is written last
    // ---------------------------------------------------------------
    always_comb begin
        found_o = 1'b0;
        index_o = 4'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pending_i[i]) begin     // Lower index overrides
                found_o = 1'b1;
                index_o = 4'(i);
            end
        end
    end
endmodule : irq_priority_pick

/* File: core/change_window_timer.sv */
// Purpose: time the change enable window
// Assumes: start and stop are single-cycle pulses
// Notes: counts down the clock cycles left after the change enable bit was set
`timescale 1ns/10ps
module change_window_timer import irq_vector_pkg::*; #(
    parameter int CYCLES = CHANGE_WINDOW_CYC
) (
    input wire logic clk_i,                 // Core clock
    input wire logic reset_i,               // Synchronous reset, high
    input wire logic start_i,               // Change enable written one
    input wire logic stop_i,                // Select written, end early
    output logic active_o,                  // Window open
    output logic expire_o                   // Window ran out, pulse
);
    logic [3:0] count;                      // Cycles left in window

    // ---------------------------------------------------------------
    // Restart wins over stop so a fresh write always opens a window
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            count <= 4'h0;
        end else if (start_i) begin
            count <= 4'(CYCLES);
        end else if (stop_i) begin
            count <= 4'h0;
        end else if (count != 4'h0) begin
            count <= count - 4'h1;
        end
    end

    assign active_o = (count != 4'h0);
    assign expire_o = (count == 4'h1) && !start_i && !stop_i;
endmodule : change_window_timer

/* File: core/interrupt_vector_placement.sv */
// Purpose: reset and interrupt vector address generation and table placement
// Assumes: core asks for a vector when it is allowed to take an interrupt
// Notes: boot start address comes from the boot size setting as an input
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/10ps
module interrupt_vector_placement import irq_vector_pkg::*; #(
    parameter int N = NUM_SRC
) (
    input wire logic clk_i,                     // Core clock, 100 MHz
    input wire logic reset_i,                   // Synchronous reset, high
    input wire logic boot_reset_fuse_i,         // Fuse level, 0 means programmed
    input wire logic [11:0] boot_start_i,       // Boot section start address
    input wire logic [N-1:0] irq_pending_i,     // Enabled pending requests
    input wire logic irq_ack_i,                 // Core takes the vector, pulse
    input wire logic instr_done_i,              // Core retired an instruction, pulse
    input wire logic [3:0] reg_addr_i,          // Register address
    input wire logic [7:0] reg_wdata_i,         // Register write data
    input wire logic reg_wr_i,                  // Register write strobe
    input wire logic reg_rd_i,                  // Register read strobe
    output logic [7:0] reg_rdata_o,             // Read data, cycle after read
    output logic [11:0] reset_addr_o,           // Reset entry address
    output logic [11:0] table_base_o,           // Vector table start
    output logic irq_req_o,                     // Vector ready for the core
    output logic [3:0] irq_index_o,             // Winning source index
    output logic [11:0] irq_addr_o,             // Winning vector address
    output logic irq_blocked_o,                 // Interrupts held off
    output logic irq_o                          // Block event interrupt
);
    // ---------------------------------------------------------------
    // Slot table
    // ---------------------------------------------------------------
    // Slot of each source, in vector number order
    function automatic logic [11:0] slot_of(input logic [3:0] idx);
        unique case (idx)
            4'd0: slot_of = SLOT_EXT_IRQ_0;
            4'd1: slot_of = SLOT_EXT_IRQ_1;
            4'd2: slot_of = SLOT_T1_CAPTURE;
            4'd3: slot_of = SLOT_T1_COMPARE_A;
            4'd4: slot_of = SLOT_T1_COMPARE_B;
            4'd5: slot_of = SLOT_T1_OVERFLOW;
            4'd6: slot_of = SLOT_T0_OVERFLOW;
            4'd7: slot_of = SLOT_SERIAL_DONE;
            4'd8: slot_of = SLOT_RX_DONE;
            4'd9: slot_of = SLOT_TX_EMPTY;
            4'd10: slot_of = SLOT_TX_DONE;
            4'd11: slot_of = SLOT_COMPARATOR;
            4'd12: slot_of = SLOT_EXT_IRQ_2;
            4'd13: slot_of = SLOT_T0_COMPARE;
            4'd14: slot_of = SLOT_EEPROM_READY;
            4'd15: slot_of = SLOT_STORE_READY;
        endcase
    endfunction : slot_of

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic fuse_meta;                // First sync stage of fuse pin
    logic fuse_sync;                // Synchronised fuse level
    logic boot_reset;               // Latched fuse state, one means boot
    logic table_select;             // Vector table in boot area
    logic ce_active;                // Change window open
    logic ce_expire;                // Window timed out
    logic ce_start;                 // Change enable written one
    logic sel_write;                // Select write inside window
    logic hold_one;                 // Block until next instruction ends
    logic [2:0] irq_status;         // Sticky events
    logic [2:0] irq_mask;           // Event mask
    logic [2:0] events;             // Event pulses this cycle
    logic pick_found;               // Any pending request
    logic [3:0] pick_index;         // Winning index
    logic ctrl_wr;                  // Control register written
    logic latch_fuse;               // Capture fuse after release
    logic [1:0] settle;             // Cycles since reset release

    assign ctrl_wr = reg_wr_i && (reg_addr_i == REG_CTRL);
    assign ce_start = ctrl_wr && reg_wdata_i[CTRL_CE_BIT];
    // Select only updates with change enable written zero inside the window
    assign sel_write = ctrl_wr && ce_active && !reg_wdata_i[CTRL_CE_BIT];

    // ---------------------------------------------------------------
    // Fuse capture
    // ---------------------------------------------------------------
    // Two-stage synchroniser on the fuse pin
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            fuse_meta <= FUSE_UNPROGRAMMED;
            fuse_sync <= FUSE_UNPROGRAMMED;
        end else begin
            fuse_meta <= boot_reset_fuse_i;
            fuse_sync <= fuse_meta;
        end
    end

    // Wait for the synchroniser to fill before latching
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            settle <= 2'd0;
        end else if (settle != 2'd3) begin
            settle <= settle + 2'd1;
        end
    end
    assign latch_fuse = (settle == 2'd2);

    // Fuse is held for the whole run; later pin changes are ignored
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            boot_reset <= 1'b0;
        end else if (latch_fuse) begin
            boot_reset <= (fuse_sync != FUSE_UNPROGRAMMED);
        end
    end

    // ---------------------------------------------------------------
    // Change enable window and table select
    // ---------------------------------------------------------------
    change_window_timer #(
        .CYCLES(CHANGE_WINDOW_CYC)
    ) u_window (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .start_i(ce_start),
        .stop_i(sel_write),
        .active_o(ce_active),
        .expire_o(ce_expire)
    );

    // A write without an open window leaves select alone
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            table_select <= CTRL_RESET[CTRL_SEL_BIT];
        end else if (sel_write) begin
            table_select <= reg_wdata_i[CTRL_SEL_BIT];
        end
    end

    // Hold off one more instruction after the select write
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            hold_one <= 1'b0;
        end else if (sel_write) begin
            hold_one <= 1'b1;
        end else if (instr_done_i) begin
            hold_one <= 1'b0;
        end
    end

    // Blocking does not touch the core's global enable flag
    assign irq_blocked_o = ce_start || ce_active || hold_one;

    // ---------------------------------------------------------------
    // Address outputs
    // ---------------------------------------------------------------
    // Reset entry follows the latched fuse
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            reset_addr_o <= RESET_APP_ADDR;
        end else begin
            reset_addr_o <= boot_reset ? boot_start_i : RESET_APP_ADDR;
        end
    end

    // Table base is zero or boot start; slot 0x001 lands one above
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            table_base_o <= SLOT_EXT_IRQ_0;
        end else begin
            table_base_o <= (table_select ? boot_start_i : RESET_APP_ADDR)
                            + SLOT_EXT_IRQ_0;
        end
    end

    irq_priority_pick #(
        .N(N)
    ) u_pick (
        .pending_i(irq_pending_i),
        .found_o(pick_found),
        .index_o(pick_index)
    );

    // Vector register; cleared while blocked or on acknowledge
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            irq_req_o <= 1'b0;
            irq_index_o <= 4'h0;
            irq_addr_o <= 12'h000;
        end else begin
            irq_req_o <= pick_found && !irq_blocked_o && !irq_ack_i;
            irq_index_o <= pick_index;
            irq_addr_o <= (table_select ? boot_start_i : RESET_APP_ADDR)
                          + slot_of(pick_index);
        end
    end

    // ---------------------------------------------------------------
    // Event interrupt
    // ---------------------------------------------------------------
    assign events[EVT_BLOCK_END] = hold_one && instr_done_i && !sel_write;
    assign events[EVT_SEL_CHANGED] = sel_write &&
                                     (reg_wdata_i[CTRL_SEL_BIT] != table_select);
    assign events[EVT_CE_TIMEOUT] = ce_expire;

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            irq_status <= 3'h0;
        end else if (reg_wr_i && reg_addr_i == REG_IRQ_STATUS) begin
            irq_status <= (irq_status & ~reg_wdata_i[2:0]) | events;
        end else begin
            irq_status <= irq_status | events;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            irq_mask <= 3'h0;
        end else if (reg_wr_i && reg_addr_i == REG_IRQ_MASK) begin
            irq_mask <= reg_wdata_i[2:0];
        end
    end

    assign irq_o = |(irq_status & irq_mask);

    // ---------------------------------------------------------------
    // Register read
    // ---------------------------------------------------------------
    // Unmapped addresses read zero
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                REG_CTRL: reg_rdata_o <= {6'h00, table_select, ce_active};
                REG_STATUS: reg_rdata_o <= {5'h00, hold_one, irq_blocked_o, boot_reset};
                REG_IRQ_STATUS: reg_rdata_o <= {5'h00, irq_status};
                REG_IRQ_MASK: reg_rdata_o <= {5'h00, irq_mask};
                default: reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end
endmodule : interrupt_vector_placement

/* File: bench/ivp_properties.sv */
// Purpose: port level checks for the vector placement block
// Assumes: one clock, synchronous active high reset
// Notes: hold-off checks rely on the core retiring instructions
`timescale 1ns/10ps
module ivp_properties import irq_vector_pkg::*; #(
    parameter int N = NUM_SRC
) (
    input wire logic clk_i, // Core clock
    input wire logic reset_i, // Sync reset
    input wire logic [N-1:0] irq_pending_i, // Pending requests
    input wire logic irq_ack_i, // Vector taken
    input wire logic instr_done_i, // Instruction retired
    input wire logic [3:0] reg_addr_i, // Register address
    input wire logic [7:0] reg_wdata_i, // Write data
    input wire logic reg_wr_i, // Write strobe
    input wire logic reg_rd_i, // Read strobe
    input wire logic [7:0] reg_rdata_o, // Read data
    input wire logic [11:0] table_base_o, // Table start
    input wire logic irq_req_o, // Vector offered
    input wire logic [3:0] irq_index_o, // Offered source
    input wire logic [11:0] irq_addr_o, // Offered address
    input wire logic irq_blocked_o // Hold-off
);
    logic ctrl_wr; // Control register write
    logic ce_wr; // Change enable written one
    logic sel_wr; // Select write with enable zero
    logic [3:0] low_idx; // Lowest pending source
    assign ctrl_wr = reg_wr_i && reg_addr_i == REG_CTRL;
    assign ce_wr = ctrl_wr && reg_wdata_i[CTRL_CE_BIT];
    assign sel_wr = ctrl_wr && !reg_wdata_i[CTRL_CE_BIT];
    // Priority reference, scanned downward so bit 0 wins
    always_comb begin
        low_idx = 4'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (irq_pending_i[i]) low_idx = 4'(i);
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    chk_ce_blocks: assert property (ce_wr |-> irq_blocked_o)
        else $error("change enable write did not block");
    chk_req_blocked: assert property (irq_blocked_o |=> !irq_req_o)
        else $error("vector offered while blocked");
    chk_req_serves: assert property (
        !irq_blocked_o && |irq_pending_i && !irq_ack_i |=> irq_req_o)
        else $error("pending request not offered");
    chk_req_lowest: assert property (
        !irq_blocked_o && |irq_pending_i && !irq_ack_i |=> irq_index_o == $past(low_idx))
        else $error("wrong source picked");
    chk_req_addr: assert property (
        irq_req_o |-> irq_addr_o == table_base_o + 12'(irq_index_o))
        else $error("vector address off its slot");
    chk_window_close: assert property (
        ce_wr ##1 (!ctrl_wr) [*4] |=> !irq_blocked_o)
        else $error("hold-off outlived the change window");
    chk_sel_hold: assert property (
        ce_wr ##1 !ctrl_wr ##1 (sel_wr && !instr_done_i) |=> irq_blocked_o)
        else $error("hold-off ended before next instruction");
    chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside its cycle");
endmodule : ivp_properties

bind interrupt_vector_placement ivp_properties #(.N(N)) u_ivp_props (
    .clk_i(clk_i), .reset_i(reset_i), .irq_pending_i(irq_pending_i),
    .irq_ack_i(irq_ack_i), .instr_done_i(instr_done_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .table_base_o(table_base_o), .irq_req_o(irq_req_o),
    .irq_index_o(irq_index_o), .irq_addr_o(irq_addr_o), .irq_blocked_o(irq_blocked_o)
);

/* File: bench/core_seq_model.sv */
// Purpose: core side model that takes vectors and retires instructions
// Assumes: take delay set by the bench, prompt or slow
// Notes: one instruction retires every third cycle
`timescale 1ns/10ps
module core_seq_model (
    input wire logic clk_i, // Core clock
    input wire logic reset_i, // Sync reset
    input wire logic irq_req_i, // Vector offered
    input wire logic [3:0] ack_wait_i, // Cycles before taking
    output logic irq_ack_o, // Vector taken, pulse
    output logic instr_done_o // Instruction retired, pulse
);
    logic [3:0] wait_cnt; // Cycles spent waiting
    logic [1:0] step_cnt; // Instruction pacing
    // Take an offered vector after the chosen wait, one cycle pulse
    always_ff @(posedge clk_i) begin
        if (reset_i || irq_ack_o || !irq_req_i) begin
            irq_ack_o <= 1'b0;
            wait_cnt <= 4'h0;
        end else if (wait_cnt >= ack_wait_i) begin
            irq_ack_o <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
    // Steady retire pace so hold-offs always get released
    always_ff @(posedge clk_i) begin
        step_cnt <= (reset_i || step_cnt == 2'h2) ? 2'h0 : step_cnt + 2'h1;
        instr_done_o <= !reset_i && step_cnt == 2'h2;
    end
endmodule : core_seq_model

/* File: bench/interrupt_vector_placement_test.sv */
// Purpose: self-checking bench for vector placement
// Assumes: core model answers every offered vector
// Notes: expected notes queued by drivers, checked by a watcher
`timescale 1ns/10ps
module interrupt_vector_placement_test import irq_vector_pkg::*; ;
    logic clk_i = 1'b0, reset_i = 1'b1, fuse = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
    logic [11:0] boot_start = 12'h000, rst_addr, base, vaddr;
    logic [15:0] pend = 16'h0000;
    logic [3:0] addr = 4'h0, ack_wait = 4'h0, vidx;
    logic [7:0] wdata = 8'h00, rdata;
    logic req, blocked, irq, ack, done, rd_seen = 1'b0;
    int err_total = 0, checks_done = 0;
    logic [15:0] vq[$]; // Expected index and address
    logic [7:0] rq[$]; // Expected read data
    always #5 clk_i = ~clk_i;
    interrupt_vector_placement uut (.clk_i(clk_i), .reset_i(reset_i),
        .boot_reset_fuse_i(fuse), .boot_start_i(boot_start), .irq_pending_i(pend),
        .irq_ack_i(ack), .instr_done_i(done), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .reset_addr_o(rst_addr),
        .table_base_o(base), .irq_req_o(req), .irq_index_o(vidx), .irq_addr_o(vaddr),
        .irq_blocked_o(blocked), .irq_o(irq));
    core_seq_model core (.clk_i(clk_i), .reset_i(reset_i), .irq_req_i(req),
        .ack_wait_i(ack_wait), .irq_ack_o(ack), .instr_done_o(done));
    task automatic fail(string msg);
        err_total++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask : fail
    task automatic chk(logic [15:0] got, logic [15:0] exp, string msg);
        checks_done++;
        if (got !== exp) fail($sformatf("%s got %h want %h", msg, got, exp));
    endtask : chk
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run
    // Watcher: read data the cycle after a read, vectors when taken
    always @(posedge clk_i) begin
        if (rd_seen) begin
            checks_done++;
            if (rq.size() == 0 || rdata !== rq[0]) fail("read data");
            if (rq.size() != 0) void'(rq.pop_front());
        end
        rd_seen <= rd_s;
        if (req === 1'b1 && ack === 1'b1) begin
            checks_done++;
            if (vq.size() == 0 || {vidx, vaddr} !== vq[0]) fail("vector");
            if (vq.size() != 0) void'(vq.pop_front());
        end
    end
    task automatic do_reset(logic f);
        @(posedge clk_i) reset_i <= 1'b1;
        fuse <= f;
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        #1;
    endtask : do_reset
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk_i) wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_i) wr_s <= 1'b0;
        #1;
    endtask : wr
    task automatic rd_exp(logic [3:0] a, logic [7:0] e);
        rq.push_back(e);
        @(posedge clk_i) rd_s <= 1'b1;
        addr <= a;
        @(posedge clk_i) rd_s <= 1'b0;
        @(posedge clk_i);
    endtask : rd_exp
    // Offer a pending set, note the lowest source, release once taken
    task automatic vec(logic [15:0] p, logic [11:0] b);
        logic [3:0] low;
        low = 4'h0;
        for (int i = 15; i >= 0; i--) if (p[i]) low = 4'(i);
        vq.push_back({low, b + 12'(low) + 12'h001});
        @(posedge clk_i) pend <= p;
        for (int n = 0; n < 60 && ack !== 1'b1; n++) @(posedge clk_i);
        if (ack !== 1'b1) begin
            fail("vector never taken");
            complete_run();
        end
        pend <= 16'h0000;
        @(posedge clk_i);
        #1;
    endtask : vec
    initial begin
        void'($urandom(47));
        boot_start = {4'($urandom_range(1, 14)), 8'h00};
        do_reset(1'b1);
        chk(16'(rst_addr), 16'h0000, "reset entry");
        chk(16'(base), 16'h0001, "table base");
        for (int i = 0; i < 16; i++) vec(16'h0001 << i, 12'h000);
        $display("test reset_and_slots done");
        @(posedge clk_i) ack_wait <= 4'h3;
        for (int i = 0; i < 20; i++) vec(16'($urandom_range(1, 16'hFFFF)), 12'h000);
        $display("test priority done");
        wr(REG_CTRL, 8'h01);
        wr(REG_CTRL, 8'h02);
        repeat (6) @(posedge clk_i);
        #1;
        chk(16'(base), 16'(boot_start + 12'h001), "boot base");
        rd_exp(REG_CTRL, 8'h02);
        rd_exp(REG_IRQ_STATUS, 8'h03);
        vec(16'h8000, boot_start);
        wr(REG_IRQ_MASK, 8'h02);
        chk(16'(irq), 16'h0001, "irq raised");
        wr(REG_IRQ_STATUS, 8'h03);
        chk(16'(irq), 16'h0000, "irq cleared");
        wr(REG_CTRL, 8'h00);
        chk(16'(base), 16'(boot_start + 12'h001), "unguarded select");
        $display("test select_move done");
        wr(REG_CTRL, 8'h01);
        chk(16'(blocked), 16'h0001, "window blocks");
        vec(16'h0010, boot_start);
        rd_exp(REG_IRQ_STATUS, 8'h04);
        chk(16'(irq), 16'h0000, "timeout masked");
        wr(REG_IRQ_MASK, 8'h04);
        chk(16'(irq), 16'h0001, "timeout irq");
        wr(REG_IRQ_STATUS, 8'h04);
        wr(REG_CTRL, 8'h01);
        wr(REG_CTRL, 8'h00);
        repeat (6) @(posedge clk_i);
        #1;
        chk(16'(base), 16'h0001, "back to app");
        chk(16'(irq), 16'h0000, "irq masked");
        rd_exp(4'hF, 8'h00);
        $display("test timeout_and_return done");
        do_reset(1'b0);
        chk(16'(rst_addr), 16'(boot_start), "boot entry");
        chk(16'(base), 16'h0001, "base after reset");
        rd_exp(REG_STATUS, 8'h01);
        $display("test boot_fuse done");
        complete_run();
    end
endmodule : interrupt_vector_placement_test
